// >>> logic/hgpl_pkg.sv
// Constants and types for the horizontal genlock loop logic
package hgpl_pkg;
  // Clock rate and derived times
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SYNC_DELAY_NS = 200;
  localparam int SYNC_DELAY_CYC = (SYNC_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam int LOCK_WIN_NS = 50;
  localparam int LOCK_WIN_CYC_I = (LOCK_WIN_NS * 1000) / CLK_PERIOD_PS;
  localparam int LOCK_WIN_CYC = (LOCK_WIN_CYC_I < 1) ? 1 : LOCK_WIN_CYC_I;
  localparam int FAST_WIN_CYC = 4 * LOCK_WIN_CYC;
  localparam int CNT_W = 12;
  localparam int ERR_W = 12;
  localparam int PULSE_CYC = 8;
  // Divisor table
  localparam logic [CNT_W-1:0] DIV_0 = 12'd851;
  localparam logic [CNT_W-1:0] DIV_1 = 12'd864;
  localparam logic [CNT_W-1:0] DIV_2 = 12'd944;
  localparam logic [CNT_W-1:0] DIV_3 = 12'd1135;
  localparam logic [CNT_W-1:0] DIV_4 = 12'd682;
  localparam logic [CNT_W-1:0] DIV_5 = 12'd858;
  localparam logic [CNT_W-1:0] DIV_6 = 12'd780;
  localparam logic [CNT_W-1:0] DIV_7 = 12'd910;
  // AXI register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_PHASE = 8'h10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Event bit positions
  localparam int EV_LOCK = 0;
  localparam int EV_UNLOCK = 1;
  localparam int EV_FASTRST = 2;
  localparam int EV_W = 3;
  // Mode code
  typedef enum logic [1:0] {
    HGPL_NORMAL = 2'b00,
    HGPL_FAST = 2'b01,
    HGPL_COAST = 2'b10
  } hgpl_mode_t;
  // Phase detector state, one-hot
  typedef enum logic [2:0] {
    HGPL_IDLE = 3'b001,
    HGPL_UP = 3'b010,
    HGPL_DOWN = 3'b100
  } hgpl_pd_t;
endpackage

// >>> logic/hgpl_top.sv
// Horizontal genlock loop: sync delay, divider, detector, lock flag
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module hgpl_top
  import hgpl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic line_sync_n,
  input wire logic divisor_select_msb,
  input wire logic divisor_select_mid,
  input wire logic divisor_select_lsb,
  input wire logic divider_source_sel,
  input wire logic hold_mode_high,
  input wire logic hold_mode_low,
  input wire logic feedback_divider_pin_i,
  output logic feedback_divider_pin_o,
  output logic feedback_divider_pin_oe,
  output logic clock_out_en,
  output logic pump_up,
  output logic pump_down,
  output logic pump_oe,
  output logic lock_indicator_flag,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Synchronisers for pin inputs: first stage feeds only second stage
  logic [6:0] pin_s1;
  logic [6:0] pin_s2;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= 7'h7F;
      pin_s2 <= 7'h7F;
    end else if (clk_en) begin
      pin_s1 <= {line_sync_n, divisor_select_msb, divisor_select_mid,
                 divisor_select_lsb, divider_source_sel, hold_mode_high,
                 hold_mode_low};
      pin_s2 <= pin_s1;
    end
  end
  logic sync_n_s;
  logic [2:0] sel_s;
  logic src_int;
  logic hm_hi;
  logic hm_lo;
  assign sync_n_s = pin_s2[6];
  assign sel_s = pin_s2[5:3];
  assign src_int = pin_s2[2];
  assign hm_hi = pin_s2[1];
  assign hm_lo = pin_s2[0];

  // External feedback synchroniser
  logic fb_s1;
  logic fb_s2;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fb_s1 <= 1'b0;
      fb_s2 <= 1'b0;
    end else if (clk_en) begin
      fb_s1 <= feedback_divider_pin_i;
      fb_s2 <= fb_s1;
    end
  end

  // Control register bits from software
  logic [31:0] ctrl;
  logic sw_override;
  logic [1:0] sw_mode;
  assign sw_override = ctrl[2];
  assign sw_mode = ctrl[1:0];

  // Three-level hold input decoded from two comparator levels
  hgpl_mode_t mode;
  always_comb begin
    if (sw_override) begin
      mode = hgpl_mode_t'(sw_mode);
    end else if (hm_hi) begin
      mode = HGPL_COAST;
    end else if (!hm_lo) begin
      mode = HGPL_NORMAL;
    end else begin
      mode = HGPL_FAST;
    end
  end

  // Divisor lookup
  logic [CNT_W-1:0] div_n;
  always_comb begin
    case (sel_s)
      3'b000: div_n = DIV_0;
      3'b001: div_n = DIV_1;
      3'b010: div_n = DIV_2;
      3'b011: div_n = DIV_3;
      3'b100: div_n = DIV_4;
      3'b101: div_n = DIV_5;
      3'b110: div_n = DIV_6;
      default: div_n = DIV_7;
    endcase
  end

  // Sync delay line; its falling edge is the phase reference
  logic [SYNC_DELAY_CYC-1:0] dly;
  logic sync_prev;
  logic ref_edge;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dly <= '1;
      sync_prev <= 1'b1;
    end else if (clk_en) begin
      dly <= {dly[SYNC_DELAY_CYC-2:0], sync_n_s};
      sync_prev <= dly[SYNC_DELAY_CYC-1];
    end
  end
  assign ref_edge = sync_prev && !dly[SYNC_DELAY_CYC-1];

  // Divide-by-N counter; feedback rises at count zero
  logic [CNT_W-1:0] cnt;
  logic int_fb;
  logic fast_reset;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
    end else if (clk_en) begin
      if (fast_reset) begin
        cnt <= '0;
      end else if (cnt >= div_n - 12'd1) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + 12'd1;
      end
    end
  end
  assign int_fb = (cnt < (div_n >> 1));

  // Feedback choice and its rising edge
  logic fb_sel;
  logic fb_prev;
  logic fb_edge;
  assign fb_sel = src_int ? int_fb : fb_s2;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fb_prev <= 1'b1;
    end else if (clk_en) begin
      // A restart must show as a fresh edge, even if feedback was high
      fb_prev <= fast_reset ? 1'b0 : fb_sel;
    end
  end
  assign fb_edge = fb_sel && !fb_prev;

  // Feedback pin drive and clock output enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      feedback_divider_pin_o <= 1'b0;
      feedback_divider_pin_oe <= 1'b0;
      clock_out_en <= 1'b0;
    end else if (clk_en) begin
      feedback_divider_pin_o <= int_fb;
      feedback_divider_pin_oe <= src_int;
      clock_out_en <= 1'b1;
    end
  end

  // Phase/frequency detector: whichever edge comes first leads
  hgpl_pd_t pd;
  hgpl_pd_t next_pd;
  logic [ERR_W-1:0] err_cnt;
  logic [ERR_W-1:0] last_err;
  logic last_sign;
  logic err_done;
  always_comb begin
    next_pd = pd;
    case (pd)
      HGPL_IDLE: begin
        if (ref_edge && fb_edge) begin
          next_pd = HGPL_IDLE;
        end else if (ref_edge) begin
          next_pd = HGPL_UP;
        end else if (fb_edge) begin
          next_pd = HGPL_DOWN;
        end
      end
      HGPL_UP: begin
        if (fb_edge) begin
          next_pd = HGPL_IDLE;
        end
      end
      HGPL_DOWN: begin
        if (ref_edge) begin
          next_pd = HGPL_IDLE;
        end
      end
      default: next_pd = HGPL_IDLE;
    endcase
    // A restart counts as sync leading; its forced edge closes the
    // measurement next cycle, else it would open a false sink phase
    if (fast_reset) begin
      next_pd = HGPL_UP;
    end
    if (mode == HGPL_COAST) begin
      next_pd = HGPL_IDLE;
    end
  end
  assign err_done = (pd != HGPL_IDLE) && (next_pd == HGPL_IDLE);

  // Detector state and error measurement
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd <= HGPL_IDLE;
      err_cnt <= '0;
      last_err <= '0;
      last_sign <= 1'b0;
    end else if (clk_en) begin
      pd <= next_pd;
      if ((pd == HGPL_IDLE) || fast_reset) begin
        err_cnt <= '0; // Restart measures from the reference edge
      end else if (err_cnt != '1) begin
        err_cnt <= err_cnt + 12'd1; // saturates on missing edges
      end
      if (err_done) begin
        last_err <= err_cnt;
        last_sign <= (pd == HGPL_UP);
      end
    end
  end

  // Large last error of either sign, or a second sync edge while sourcing, in fast mode with the internal divider restarts the counter
  assign fast_reset = (mode == HGPL_FAST) && src_int && ref_edge &&
    ((pd == HGPL_UP) || (last_err >= FAST_WIN_CYC[ERR_W-1:0]));

  // Charge pump commands; floats when idle or coasting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pump_up <= 1'b0;
      pump_down <= 1'b0;
      pump_oe <= 1'b0;
    end else if (clk_en) begin
      pump_up <= (next_pd == HGPL_UP);
      pump_down <= (next_pd == HGPL_DOWN);
      pump_oe <= (next_pd != HGPL_IDLE);
    end
  end

  // Lock judgement: each measured error compared to the window
  logic locked;
  logic [3:0] pulse_cnt;
  logic ev_lock;
  logic ev_unlock;
  logic in_win;
  assign in_win = last_err < LOCK_WIN_CYC[ERR_W-1:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      locked <= 1'b0;
    end else if (clk_en && err_done) begin
      locked <= err_cnt < LOCK_WIN_CYC[ERR_W-1:0];
    end
  end
  assign ev_lock = clk_en && err_done && !locked &&
    (err_cnt < LOCK_WIN_CYC[ERR_W-1:0]);
  assign ev_unlock = clk_en && err_done && locked &&
    !(err_cnt < LOCK_WIN_CYC[ERR_W-1:0]);

  // Out of lock the flag pulses high once per reference edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_cnt <= '0;
      lock_indicator_flag <= 1'b1;
    end else if (clk_en) begin
      if (ref_edge && !locked) begin
        pulse_cnt <= 4'(PULSE_CYC);
      end else if (pulse_cnt != '0) begin
        pulse_cnt <= pulse_cnt - 4'd1;
      end
      // A pulse begun out of lock runs its full length so the pin
      // always shows a usable width; it may outlast a new lock briefly
      lock_indicator_flag <= (pulse_cnt != '0);
    end
  end

  // AXI4-Lite write path: address and data in either order
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [EV_W-1:0] irq_mask;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl <= CTRL_RESET;
      irq_mask <= MASK_RESET[EV_W-1:0];
    end else if (clk_en) begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= RESP_OKAY;
        case (aw_addr)
          REG_CTRL: if (w_strb[0]) ctrl[2:0] <= w_data[2:0];
          REG_IRQ_MASK: if (w_strb[0]) irq_mask <= w_data[EV_W-1:0];
          REG_STATUS, REG_IRQ_STAT, REG_PHASE: ;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Sticky events; a read of the IRQ status clears, but a set wins
  logic [EV_W-1:0] irq_stat;
  logic rd_stat;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
    end else if (clk_en) begin
      irq_stat <= (rd_stat ? '0 : irq_stat) |
        {fast_reset, ev_unlock, ev_lock};
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // AXI4-Lite read path
  assign rd_stat = s_axi_arvalid && s_axi_arready &&
    (s_axi_araddr == REG_IRQ_STAT);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          REG_CTRL: s_axi_rdata <= {29'h0, ctrl[2:0]};
          REG_STATUS: s_axi_rdata <= {24'h0, pump_oe, pump_down, pump_up,
            locked, src_int, mode, lock_indicator_flag};
          REG_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat};
          REG_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask};
          REG_PHASE: s_axi_rdata <= {19'h0, last_sign, last_err};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  logic unused_ok;
  assign unused_ok = in_win;
endmodule

// >>> bench/hgpl_properties.sv
// Pin-level checks for the genlock loop logic
`timescale 1ns/1ps
module hgpl_properties
  import hgpl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic divisor_select_msb,
  input wire logic divisor_select_mid,
  input wire logic divisor_select_lsb,
  input wire logic divider_source_sel,
  input wire logic hold_mode_high,
  input wire logic hold_mode_low,
  input wire logic feedback_divider_pin_o,
  input wire logic feedback_divider_pin_oe,
  input wire logic pump_up,
  input wire logic pump_down,
  input wire logic pump_oe,
  input wire logic lock_indicator_flag
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Divisor per select code
  localparam logic [CNT_W-1:0] DIVS [8] = '{DIV_0, DIV_1, DIV_2, DIV_3,
    DIV_4, DIV_5, DIV_6, DIV_7};
  logic [2:0] code; // Select code as seen now
  logic [2:0] code_q; // Select code one cycle back
  logic fb_q; // Feedback one cycle back
  logic rise; // Feedback rising edge
  logic calm; // Nothing that could bend a period is moving
  logic [CNT_W-1:0] gap; // Cycles since the last feedback rise
  logic [1:0] arm; // Rises seen since the last disturbance
  assign code = {divisor_select_msb, divisor_select_mid, divisor_select_lsb};
  assign rise = feedback_divider_pin_o && !fb_q;
  assign calm = clk_en && divider_source_sel && !hold_mode_low &&
    !hold_mode_high && code == code_q;
  // Period tracker; two rises are skipped since inputs pass synchronisers
  always_ff @(posedge aclk) begin
    fb_q <= feedback_divider_pin_o;
    code_q <= code;
    gap <= rise ? CNT_W'(1) : gap + CNT_W'(1);
    if (!aresetn || !calm)
      arm <= 2'h0;
    else if (rise && arm != 2'h3)
      arm <= arm + 2'h1;
  end
  chk_pump_onehot:
    assert property (!(pump_up && pump_down))
    else $error("pump sources and sinks together");
  chk_pump_float:
    assert property (pump_oe |-> pump_up || pump_down)
    else $error("pump driven with no command");
  chk_coast_float:
    assert property (hold_mode_high [*8] |-> !pump_oe)
    else $error("pump driven in coast");
  chk_fb_drive:
    assert property (divider_source_sel [*6] |-> feedback_divider_pin_oe)
    else $error("feedback pin not driven");
  chk_fb_release:
    assert property (!divider_source_sel [*6] |-> !feedback_divider_pin_oe)
    else $error("feedback pin driven in external mode");
  chk_lock_pulse:
    assert property ($rose(lock_indicator_flag) |-> lock_indicator_flag [*8])
    else $error("lock flag pulse too short");
  chk_up_ends:
    assert property ($rose(feedback_divider_pin_o) && feedback_divider_pin_oe
      |-> ##[0:4] !pump_up)
    else $error("source command outlives feedback edge");
  chk_div_period:
    assert property (rise && arm >= 2'h2 |-> gap == DIVS[code])
    else $error("feedback period differs from divisor");
endmodule
bind hgpl_top hgpl_properties u_props (.aclk, .aresetn, .clk_en,
  .divisor_select_msb, .divisor_select_mid, .divisor_select_lsb,
  .divider_source_sel, .hold_mode_high, .hold_mode_low,
  .feedback_divider_pin_o, .feedback_divider_pin_oe, .pump_up, .pump_down,
  .pump_oe, .lock_indicator_flag);

// >>> bench/hgpl_partner.sv
// Far side: sync separator output and an external divider
`timescale 1ns/1ps
module hgpl_partner (
  input wire logic aclk,
  input wire logic run,
  input wire logic [11:0] line_cyc,
  input wire logic [11:0] ext_cyc,
  input wire logic drive,
  output logic line_sync_n,
  output logic ext_fb
);
  logic [11:0] lc = 12'h000; // Position within the line
  logic [11:0] ec = 12'h000; // Position within the divider cycle
  // Sync: 16-cycle low pulse per line, idle high while stopped
  always_ff @(posedge aclk) begin
    lc <= (!run || lc >= line_cyc - 12'h001) ? 12'h000 : lc + 12'h001;
    line_sync_n <= !(run && lc < 12'h010);
  end
  // Custom ratio; toggles when released so no stale level lingers
  always_ff @(posedge aclk) begin
    ec <= (ec >= ext_cyc - 12'h001) ? 12'h000 : ec + 12'h001;
    ext_fb <= drive ? (ec < (ext_cyc >> 1)) : !ext_fb;
  end
endmodule

// >>> bench/tb.sv
// Self-checking bench for the genlock loop logic
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("unexpected %s: expected %0h seen %0h", nm, e, g); \
    end \
  end
module tb
  import hgpl_pkg::*;
;
  int mismatches = 0;
  int tests_run = 0;
  int n, nu, nd, nf; // Period and pump/flag activity counts
  int since = 0; // Cycles since the last sync fall
  int divs [8] = '{851, 864, 944, 1135, 682, 858, 780, 910};
  logic [1:0] hm [3] = '{2'h0, 2'h1, 2'h3}; // Hold pins per mode
  hgpl_mode_t md [3] = '{HGPL_NORMAL, HGPL_FAST, HGPL_COAST};
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, run = 1'b0;
  logic divider_source_sel = 1'b1, hold_mode_high = 1'b0;
  logic hold_mode_low = 1'b0, sync_q = 1'b1;
  logic [2:0] sel = 3'h0;
  logic [11:0] lcyc = 12'h38E, ecyc = 12'h190; // 910 and 400
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic sync_n, ext_fb, fb_o, fb_oe, clock_out_en, pump_up, pump_down;
  logic pump_oe, flag, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  wire logic fb_i = fb_oe ? fb_o : ext_fb; // Shared feedback wire
  initial forever #2 aclk = ~aclk;
  hgpl_partner u_far (.aclk, .run, .line_cyc(lcyc), .ext_cyc(ecyc),
    .drive(!fb_oe), .line_sync_n(sync_n), .ext_fb);
  hgpl_top u_dut (.aclk, .aresetn, .clk_en, .line_sync_n(sync_n),
    .divisor_select_msb(sel[2]), .divisor_select_mid(sel[1]),
    .divisor_select_lsb(sel[0]), .divider_source_sel, .hold_mode_high,
    .hold_mode_low, .feedback_divider_pin_i(fb_i),
    .feedback_divider_pin_o(fb_o), .feedback_divider_pin_oe(fb_oe),
    .clock_out_en, .pump_up, .pump_down, .pump_oe,
    .lock_indicator_flag(flag), .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // Sync fall tracker, sampled where outputs have settled
  always @(negedge aclk) begin
    since <= (sync_q && !sync_n) ? 0 : since + 1;
    sync_q <= sync_n;
  end
  // Register write; address and data released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
      output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Register read
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
      output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Tally pump and flag activity over a span
  task automatic watch(input int c);
    nu = 0;
    nd = 0;
    nf = 0;
    repeat (c) begin
      @(negedge aclk);
      nu += pump_up;
      nd += pump_down;
      nf += flag;
    end
  endtask
  // Cycles to the next feedback rise, bounded
  task automatic rise(output int k);
    logic p;
    k = 0;
    p = fb_o;
    forever begin
      @(negedge aclk);
      k++;
      if (k > 4000 || (fb_o === 1'b1 && p === 1'b0)) break;
      p = fb_o;
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard, well past the expected run of about 39k cycles
  initial begin
    #360_000;
    mismatches++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_CTRL, d, r);
    `CHK("ctrl", CTRL_RESET, d)
    rd(REG_IRQ_MASK, d, r);
    `CHK("mask", MASK_RESET, d)
    rd(8'h40, d, r);
    `CHK("bad read", RESP_SLVERR, r)
    `CHK("bad data", 32'h0000_0000, d)
    wr(8'h40, 32'h0000_0001, r);
    `CHK("bad write", RESP_SLVERR, r)
    `CHK("clock out", 1'b1, clock_out_en)
    // Every select code; the third period is clear of the change
    for (int c = 0; c < 8; c++) begin
      @(posedge aclk);
      sel <= 3'(c);
      repeat (3) rise(n);
      `CHK("period", divs[c], n)
    end
    `CHK("fb drive", 1'b1, fb_oe)
    // Enable low freezes the divider: no feedback rise in the bound
    @(posedge aclk);
    clk_en <= 1'b0;
    rise(n);
    `CHK("frozen", 4001, n)
    @(posedge aclk);
    clk_en <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      @(posedge aclk);
      {hold_mode_high, hold_mode_low} <= hm[m];
      repeat (8) @(posedge aclk);
      rd(REG_STATUS, d, r);
      `CHK("mode", md[m], d[2:1])
    end
    // Coast with off-rate sync: pump stays quiet
    lcyc <= 12'h2BC;
    run <= 1'b1;
    watch(3000);
    `CHK("coast", 0, nu + nd)
    // Fast lock onto a matching line rate
    wr(REG_IRQ_MASK, 32'h0000_0007, r);
    // Clear while still coasting, so no restart is lost to the read
    rd(REG_IRQ_STAT, d, r);
    lcyc <= 12'h38E;
    {hold_mode_high, hold_mode_low} <= 2'h1;
    watch(2730);
    watch(910);
    `CHK("fast lock", 0, nf)
    rise(n);
    `CHK("edge delay", 1'b1, since > 38 && since < 64)
    `CHK("irq set", 1'b1, irq)
    rd(REG_IRQ_STAT, d, r);
    `CHK("events", 3'h5, d[2:0] & 3'h5)
    repeat (3) @(negedge aclk);
    `CHK("irq clear", 1'b0, irq)
    // Faster sync in normal mode, loss event masked
    wr(REG_IRQ_MASK, 32'h0000_0000, r);
    {hold_mode_high, hold_mode_low} <= 2'h0;
    lcyc <= 12'h2BC;
    watch(3000);
    `CHK("masked", 1'b0, irq)
    `CHK("sources", 1'b1, nu > nd)
    `CHK("pulses", 1'b1, nf > 0)
    wr(REG_IRQ_MASK, 32'h0000_0002, r);
    repeat (3) @(negedge aclk);
    `CHK("unmasked", 1'b1, irq)
    // External divider faster than the line: pump sinks
    divider_source_sel <= 1'b0;
    lcyc <= 12'h1F4;
    watch(3000);
    `CHK("fb free", 1'b0, fb_oe)
    `CHK("sinks", 1'b1, nd > nu)
    conclude();
  end
endmodule
